//--- pdc_config_regs.sv
// Configuration register bank of the PHY datapath, AHB-Lite slave.
// Assumes one master, single word transfers, wait states only while ce is low, and a
// strap pin that is stable around reset release.
//
// Overview of operation
// [RL1] Interface control reserved bits: ignore, read zero
// [RL2] Bit 7 enables interface; strap on large package
// [RL3] Bits 6:5 receive FIFO half level, reset 10
// [RL4] Bits 4:3 transmit FIFO half level, reset 10
// [RL5] Bit 1 shifts transmit clock against data
// [RL6] Bit 0 shifts receive clock against data
// [RL7] Second control bit 4 bypasses async FIFO
// [RL8] Bit 11 selects descrambler timeout cut-off policy
// [RL9] Bits 10:7 descrambler recovery milliseconds, reset 1111
// [RL10] Bit 6 forces good 100 Mbps link
// [RL11] Bit 5 enhanced line code detect, reset 1
// [RL12] Bit 4 enhanced inter-packet gap detect
// [RL13] Bit 3 skips receive symbol decoder
// [RL14] Bit 2 turns scrambler off
// [RL15] Bit 1 detects odd nibble count
// [RL16] Bit 0 quick receive valid assertion
// [RL17] Bits 3:0 idle symbol threshold, reset 0x5
// [RL18] Software keeps 0x5, or 0x4 for short gaps
// [RL19] 16-bit registers, writes immediate, read-only fixed
`timescale 1ns/1ps
`include "pdc_map.svh"

module pdc_config_regs #(
  parameter bit LARGE_PACKAGE = 1'b0
) (
  // Clock, reset, freeze
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Strap sampled after reset release
  input  wire logic             ifEnableStrap,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  // Decoded configuration
  output pdc_pkg::pdc_cfg_s     cfg
);
  import pdc_pkg::*;

  localparam int NREG = 4;
  localparam pdc_word_t WMASK [NREG] = '{
    `PDC_WMASK_MAC_CTL, `PDC_WMASK_MAC_CTL_TWO,
    `PDC_WMASK_FAST_ETH, `PDC_WMASK_IDLE_DET};
  localparam pdc_word_t RSTV [NREG] = '{
    `PDC_RST_MAC_CTL, `PDC_RST_MAC_CTL_TWO,
    `PDC_RST_FAST_ETH, `PDC_RST_IDLE_DET};

  // ================================================================
  // Address phase
  logic       addrTake;
  logic       addrHit;
  logic [1:0] addrSel;
  logic       wrPendFf;
  logic [1:0] wrSelFf;
  logic       strapDoneFf;
  logic [31:0] hrdataFf;
  pdc_word_t  regFf  [NREG];
  pdc_word_t  nxt_reg [NREG];

  // Frozen while ce is low, so the master simply waits
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdataFf;
  assign addrTake  = ce && hsel && hready && htrans[1];

  always_comb begin
    addrHit = 1'b1;
    addrSel = 2'd0;
    case (haddr[11:2])
      `PDC_IDX_MAC_CTL:     addrSel = 2'd0;
      `PDC_IDX_MAC_CTL_TWO: addrSel = 2'd1;
      `PDC_IDX_FAST_ETH:    addrSel = 2'd2;
      `PDC_IDX_IDLE_DET:    addrSel = 2'd3;
      default:              addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPendFf <= 1'b0;
      wrSelFf  <= 2'd0;
    end else if (ce) begin
      wrPendFf <= addrTake && hwrite && addrHit;
      wrSelFf  <= addrSel;
    end
  end

  // ================================================================
  // Register storage
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      nxt_reg[i] = regFf[i];
      // [RL19] Masked immediate write
      // [RL1] Reserved bits keep fixed value
      if (wrPendFf && wrSelFf == 2'(i)) begin
        nxt_reg[i] = (regFf[i] & ~WMASK[i]) | (hwdata[15:0] & WMASK[i]);
      end
    end
    // [RL2] Strap sets enable on large package
    if (!strapDoneFf && LARGE_PACKAGE) begin
      nxt_reg[0][`PDC_BIT_IF_ENABLE] = ifEnableStrap;
    end
  end

  // One storage word per register, each with its own reset value
  for (genvar g = 0; g < NREG; g++) begin : gRegs
    pdc_reg_word #(
      .RST_VAL  (RSTV[g])
    ) i_pdc_reg_word (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .nxt_word (nxt_reg[g]),
      .wordFf   (regFf[g])
    );
  end

  // Strap taken once, at the first enabled edge after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapDoneFf <= 1'b0;
    end else if (ce) begin
      strapDoneFf <= 1'b1;
    end
  end

  // ================================================================
  // Read data
  // Read from next values so a read right after a write sees it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdataFf <= 32'h0000_0000;
    end else if (ce && addrTake && !hwrite) begin
      hrdataFf <= addrHit ? {16'h0000, nxt_reg[addrSel]} : 32'h0000_0000;
    end
  end

  // ================================================================
  // Configuration outputs
  always_comb begin
    // [RL2] Interface enable
    cfg.macIfEnable              = regFf[0][7];
    // [RL3] Receive FIFO half level
    cfg.rxFifoHalfLevel          = regFf[0][6:5];
    // [RL4] Transmit FIFO half level
    cfg.txFifoHalfLevel          = regFf[0][4:3];
    // [RL5] Transmit clock shift
    cfg.txClkShift               = regFf[0][1];
    // [RL6] Receive clock shift
    cfg.rxClkShift               = regFf[0][0];
    // [RL7] Async FIFO bypass
    cfg.asyncFifoBypass          = regFf[1][4];
    // [RL8] Timeout cut-off policy
    cfg.descramblerTimeoutPolicy = regFf[2][11];
    // [RL9] Recovery time in ms
    cfg.descramblerRecoveryMs    = regFf[2][10:7];
    // [RL10] Forced good link
    cfg.forceGoodLink            = regFf[2][6];
    // [RL11] Enhanced line code detect
    cfg.enhancedLineCodeDetect   = regFf[2][5];
    // [RL12] Enhanced gap detect
    cfg.enhancedGapDetect        = regFf[2][4];
    // [RL13] Symbol decoder skip
    cfg.rxSymbolDecoderSkip      = regFf[2][3];
    // [RL14] Scrambler off
    cfg.scramblerOff             = regFf[2][2];
    // [RL15] Odd nibble detect
    cfg.oddNibbleDetect          = regFf[2][1];
    // [RL16] Quick receive valid
    cfg.quickReceiveValid        = regFf[2][0];
    // [RL17] Idle symbol threshold
    cfg.idleSymbolThreshold      = regFf[3][3:0];
  end

  // ================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sWriteAddr(logic [9:0] idx);
    addrTake && hwrite && haddr[11:2] == idx;
  endsequence

  sequence sReadAddr(logic [9:0] idx);
    addrTake && !hwrite && haddr[11:2] == idx;
  endsequence

  // Write that no register claims; must leave the bank alone
  sequence sUnmappedWrite;
    addrTake && hwrite && !addrHit;
  endsequence

  // Address phase of a write followed by an enabled data phase
  sequence sWriteLands(logic [9:0] idx);
    sWriteAddr(idx) ##1 ce;
  endsequence

  a_ctl_reserved_zero: assert property ( // [RL1]
    sReadAddr(`PDC_IDX_MAC_CTL) |=> hrdata[15:8] == 8'h00 && !hrdata[2])
    else $error("reserved interface control bits not zero");

  a_enable_small_pkg: assert property ( // [RL2]
    !LARGE_PACKAGE && !strapDoneFf |-> cfg.macIfEnable)
    else $error("interface enable not set after reset");

  a_enable_strap_take: assert property ( // [RL2]
    LARGE_PACKAGE && ce && !strapDoneFf |=> cfg.macIfEnable == $past(ifEnableStrap))
    else $error("strap not captured into interface enable");

  a_rx_level_write: assert property ( // [RL3]
    sWriteAddr(`PDC_IDX_MAC_CTL) ##1 ce
    |=> cfg.rxFifoHalfLevel == $past(hwdata[6:5]))
    else $error("receive half level not written");

  a_tx_shift_write: assert property ( // [RL5]
    sWriteAddr(`PDC_IDX_MAC_CTL) ##1 ce
    |=> cfg.txClkShift == $past(hwdata[1]) && cfg.rxClkShift == $past(hwdata[0]))
    else $error("clock shift bits not written");

  a_ctl_two_ro: assert property ( // [RL7]
    sReadAddr(`PDC_IDX_MAC_CTL_TWO) |=> hrdata[15:5] == 11'h000 && hrdata[3:0] == 4'h0)
    else $error("second control read-only bits not zero");

  a_bypass_write: assert property ( // [RL7]
    sWriteAddr(`PDC_IDX_MAC_CTL_TWO) ##1 ce
    |=> cfg.asyncFifoBypass == $past(hwdata[4]))
    else $error("async bypass not written");

  a_fast_eth_write: assert property ( // [RL9]
    sWriteAddr(`PDC_IDX_FAST_ETH) ##1 ce
    |=> cfg.descramblerRecoveryMs == $past(hwdata[10:7])
        && cfg.descramblerTimeoutPolicy == $past(hwdata[11]))
    else $error("fast ethernet fields not written");

  a_fast_eth_ro: assert property ( // [RL19]
    sReadAddr(`PDC_IDX_FAST_ETH) |=> hrdata[15:12] == 4'h0)
    else $error("fast ethernet upper bits not zero");

  a_idle_fixed_hi: assert property ( // [RL17]
    sReadAddr(`PDC_IDX_IDLE_DET) |=> hrdata[15:4] == `PDC_IDLE_FIXED_HI
    && hrdata[3:0] == cfg.idleSymbolThreshold)
    else $error("idle register readback wrong");

  a_freeze_cfg: assert property ( // [RL19]
    !ce |=> $stable(cfg))
    else $error("configuration changed while frozen");

  a_ahb_okay: assert property (
    hresp == 1'b0 && hreadyout == ce)
    else $error("slave response not okay");

  a_upper_zero: assert property ( // [RL19]
    addrTake && !hwrite |=> hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  // ================================================================
  // Write landing, field by field
  a_ctl_write_mask: assert property ( // [RL1]
    sWriteLands(`PDC_IDX_MAC_CTL)
    |=> regFf[0][15:8] == 8'h00 && !regFf[0][2])
    else $error("reserved interface control bits took a write");

  a_enable_write: assert property ( // [RL2]
    sWriteLands(`PDC_IDX_MAC_CTL)
    |=> cfg.macIfEnable == $past(hwdata[7]))
    else $error("interface enable not written");

  a_tx_level_write: assert property ( // [RL4]
    sWriteLands(`PDC_IDX_MAC_CTL)
    |=> cfg.txFifoHalfLevel == $past(hwdata[4:3]))
    else $error("transmit half level not written");

  a_ctl_two_mask: assert property ( // [RL7]
    sWriteLands(`PDC_IDX_MAC_CTL_TWO)
    |=> regFf[1] == {11'h000, $past(hwdata[4]), 4'h0})
    else $error("second control read-only bits took a write");

  a_policy_write: assert property ( // [RL8]
    sWriteLands(`PDC_IDX_FAST_ETH)
    |=> cfg.descramblerTimeoutPolicy == $past(hwdata[11]))
    else $error("timeout policy not written");

  a_link_force_write: assert property ( // [RL10]
    sWriteLands(`PDC_IDX_FAST_ETH)
    |=> cfg.forceGoodLink == $past(hwdata[6]))
    else $error("forced link not written");

  a_line_code_write: assert property ( // [RL11]
    sWriteLands(`PDC_IDX_FAST_ETH)
    |=> cfg.enhancedLineCodeDetect == $past(hwdata[5]))
    else $error("line code detect not written");

  a_gap_detect_write: assert property ( // [RL12]
    sWriteLands(`PDC_IDX_FAST_ETH)
    |=> cfg.enhancedGapDetect == $past(hwdata[4]))
    else $error("gap detect not written");

  a_decoder_skip_write: assert property ( // [RL13]
    sWriteLands(`PDC_IDX_FAST_ETH)
    |=> cfg.rxSymbolDecoderSkip == $past(hwdata[3]))
    else $error("decoder skip not written");

  a_scrambler_write: assert property ( // [RL14]
    sWriteLands(`PDC_IDX_FAST_ETH)
    |=> cfg.scramblerOff == $past(hwdata[2]))
    else $error("scrambler off not written");

  a_odd_nibble_write: assert property ( // [RL15]
    sWriteLands(`PDC_IDX_FAST_ETH)
    |=> cfg.oddNibbleDetect == $past(hwdata[1]))
    else $error("odd nibble detect not written");

  a_quick_valid_write: assert property ( // [RL16]
    sWriteLands(`PDC_IDX_FAST_ETH)
    |=> cfg.quickReceiveValid == $past(hwdata[0]))
    else $error("quick receive valid not written");

  a_fast_eth_mask: assert property ( // [RL19]
    sWriteLands(`PDC_IDX_FAST_ETH)
    |=> regFf[2][15:12] == 4'h0)
    else $error("fast ethernet upper bits took a write");

  a_idle_thr_write: assert property ( // [RL17]
    sWriteLands(`PDC_IDX_IDLE_DET)
    |=> cfg.idleSymbolThreshold == $past(hwdata[3:0]))
    else $error("idle threshold not written");

  a_idle_fixed_keep: assert property ( // [RL19]
    sWriteLands(`PDC_IDX_IDLE_DET)
    |=> regFf[3][15:4] == `PDC_IDLE_FIXED_HI)
    else $error("idle fixed bits took a write");

  // ================================================================
  // Bank integrity
  a_unmapped_ignored: assert property ( // [RL19]
    sUnmappedWrite ##1 ce |=> $stable(cfg))
    else $error("unmapped write changed configuration");

  a_unmapped_read: assert property ( // [RL19]
    addrTake && !hwrite && !addrHit |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_idle_hold: assert property ( // [RL19]
    ce && !wrPendFf && strapDoneFf |=> $stable(cfg))
    else $error("configuration changed without a write");

  a_read_hold: assert property ( // [RL19]
    !(addrTake && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

endmodule

// ==================================================================
// One configuration word: masked next value in, flop word out
module pdc_reg_word #(
  parameter pdc_pkg::pdc_word_t RST_VAL = 16'h0000
) (
  // Clock, reset, freeze
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  // Next value and stored word
  input  wire pdc_pkg::pdc_word_t nxt_word,
  output pdc_pkg::pdc_word_t      wordFf
);
  import pdc_pkg::*;

  // Holds while the bank is frozen, like every other flop here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wordFf <= RST_VAL;
    end else if (ce) begin
      wordFf <= nxt_word;
    end
  end

endmodule

//--- pdc_config_regs_bench.sv
// Self-checking bench for the PHY datapath configuration register bank.
// Assumes the bank is an AHB-Lite slave, zero-wait unless ce is low, whose hreadyout feeds hready.
`timescale 1ns/1ps

module pdc_config_regs_bench;
  import pdc_pkg::*;
  // ================================================================
  // Stimulus and observed signals
  logic        clk = 1'b0;
  logic        rstN = 1'b0;
  logic        ce = 1'b1;
  logic        ifEnableStrap = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  pdc_cfg_s    cfg;
  pdc_cfg_s    cfgLarge;
  int          mismatches = 0;
  int          checksDone = 0;
  int          cycles = 0;
  logic [31:0] regAddr [4] = '{32'h0C8, 32'h0CC, 32'h10C, 32'h14C};
  logic [15:0] rstVal  [4] = '{16'h00D0, 16'h0000, 16'h07A0, 16'h2055};
  logic [15:0] wrMask  [4] = '{16'h00FB, 16'h0010, 16'h0FFF, 16'h000F};
  logic [15:0] mdl     [4];

  pdc_config_regs i_pdc_config_regs (.clk(clk), .rst_n(rstN), .ce(ce),
    .ifEnableStrap(ifEnableStrap), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfg(cfg));

  // Large package build on the same bus, to reach the strap path
  pdc_config_regs #(.LARGE_PACKAGE(1'b1)) i_pdc_config_regs_large (
    .clk(clk), .rst_n(rstN), .ce(ce), .ifEnableStrap(ifEnableStrap), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(), .cfg(cfgLarge));

  initial begin
    forever #20 clk = ~clk;
  end

  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      completeRun();
    end
  end

  // ================================================================
  // Bus, compare and closing tasks
  task automatic xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic cmpWord(input string n, input logic [31:0] exp, got);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic cmpCfg(input string n);
    pdc_cfg_s exp;
    exp = {mdl[0][7:3], mdl[0][1:0], mdl[1][4], mdl[2][11:0], mdl[3][3:0]};
    checksDone++;
    if (cfg !== exp) begin
      mismatches++;
      $display("mismatch cfg %s expected %h seen %h", n, exp, cfg);
    end
  endtask

  task automatic completeRun();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ================================================================
  // Scenarios
  task automatic testReset(input string n, input logic s);
    logic [31:0] r;
    rstN <= 1'b0;
    ifEnableStrap <= s;
    repeat (6) @(posedge clk);
    rstN <= 1'b1;
    mdl = rstVal;
    cmpCfg(n);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, regAddr[i], 32'h0, r);
      cmpWord(n, {16'h0, rstVal[i]}, r);
    end
    cmpWord("strap enable", {31'h0, s}, {31'h0, cfgLarge.macIfEnable});
    $display("test %s done", n);
  endtask

  // Write then read back at once; reserved and fixed bits must hold
  task automatic testWrite(input logic [31:0] d);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, regAddr[i], d, r);
      mdl[i] = (mdl[i] & ~wrMask[i]) | (d[15:0] & wrMask[i]);
      xfer(1'b0, regAddr[i], 32'h0, r);
      cmpWord("readback", {16'h0, mdl[i]}, r);
      cmpWord("hresp", 32'h0, {31'h0, hresp});
    end
    cmpCfg("after write");
    $display("test write %h done", d);
  endtask

  // Unmapped place: reads zero and leaves the bank untouched
  task automatic testUnmapped();
    logic [31:0] r;
    xfer(1'b1, 32'h0D0, 32'hFFFF_FFFF, r);
    xfer(1'b0, 32'h0D0, 32'h0, r);
    cmpWord("unmapped", 32'h0, r);
    xfer(1'b0, regAddr[0], 32'h0, r);
    cmpWord("untouched", {16'h0, mdl[0]}, r);
    cmpCfg("unmapped");
    $display("test unmapped done");
  endtask

  // Frozen bank stalls the bus and holds every field
  task automatic testFreeze();
    logic [31:0] r;
    ce <= 1'b0;
    fork
      xfer(1'b1, regAddr[3], 32'h0000_0005, r);
      begin
        repeat (3) @(posedge clk);
        cmpWord("hreadyout frozen", 32'h0, {31'h0, hreadyout});
        cmpCfg("frozen");
        ce <= 1'b1;
      end
    join
    mdl[3] = (mdl[3] & ~wrMask[3]) | (16'h0005 & wrMask[3]);
    xfer(1'b0, regAddr[3], 32'h0, r);
    cmpWord("after freeze", {16'h0, mdl[3]}, r);
    cmpCfg("after freeze");
    $display("test freeze done");
  endtask

  initial begin
    testReset("reset", 1'b0);
    testWrite(32'hFFFF_FFFF);
    testWrite(32'h0000_0000);
    testWrite(32'h5555_5555);
    testWrite(32'hAAAA_AAAA);
    testWrite(32'h0000_0004);
    testUnmapped();
    testFreeze();
    testReset("second reset", 1'b1);
    completeRun();
  end
endmodule

//--- pdc_map.svh
// Register map constants for the PHY datapath configuration bank.
// Assumes a word-addressed AHB-Lite slave: byte address = index * 4.
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

// ==================================================================
// Register indices (byte address is four times the index)
`define PDC_IDX_MAC_CTL      10'h032
`define PDC_IDX_MAC_CTL_TWO  10'h033
`define PDC_IDX_FAST_ETH     10'h043
`define PDC_IDX_IDLE_DET     10'h053

// ==================================================================
// Writable bit masks
`define PDC_WMASK_MAC_CTL      16'h00FB
`define PDC_WMASK_MAC_CTL_TWO  16'h0010
`define PDC_WMASK_FAST_ETH     16'h0FFF
`define PDC_WMASK_IDLE_DET     16'h000F

// ==================================================================
// Reset values, fixed read-only bits included
`define PDC_RST_MAC_CTL      16'h00D0
`define PDC_RST_MAC_CTL_TWO  16'h0000
`define PDC_RST_FAST_ETH     16'h07A0
`define PDC_RST_IDLE_DET     16'h2055
`define PDC_IDLE_FIXED_HI    12'h205

// ==================================================================
// Field positions
`define PDC_BIT_IF_ENABLE    7

`endif

//--- pdc_pkg.sv
// Types shared by the PHY datapath configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package pdc_pkg;

  // ================================================================
  // Decoded configuration handed to the datapath
  typedef struct packed {
    logic       macIfEnable;
    logic [1:0] rxFifoHalfLevel;
    logic [1:0] txFifoHalfLevel;
    logic       txClkShift;
    logic       rxClkShift;
    logic       asyncFifoBypass;
    logic       descramblerTimeoutPolicy;
    logic [3:0] descramblerRecoveryMs;
    logic       forceGoodLink;
    logic       enhancedLineCodeDetect;
    logic       enhancedGapDetect;
    logic       rxSymbolDecoderSkip;
    logic       scramblerOff;
    logic       oddNibbleDetect;
    logic       quickReceiveValid;
    logic [3:0] idleSymbolThreshold;
  } pdc_cfg_s;

  typedef logic [15:0] pdc_word_t;

endpackage
